// >>> include/t8_defs.svh
`ifndef T8_DEFS_SVH
`define T8_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define T8_OFS_CTRL_A 4'h0
`define T8_OFS_CTRL_B 4'h1
`define T8_OFS_COUNT 4'h2
`define T8_OFS_CMP_A 4'h3
`define T8_OFS_CMP_B 4'h4
`define T8_OFS_MASK 4'h5
`define T8_OFS_FLAG 4'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define T8_CA_COM_A 7:6
`define T8_CA_COM_B 5:4
`define T8_CA_WGM_LO 1:0
`define T8_CA_WMASK 8'hF3
`define T8_CB_FORCE_A 7
`define T8_CB_FORCE_B 6
`define T8_CB_WGM_HI 3
`define T8_CB_SEL 2:0
`define T8_FLG_OVF 0
`define T8_FLG_MA 1
`define T8_FLG_MB 2

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define T8_RST_BYTE 8'h00
`define T8_RST_BITS3 3'h0
`define T8_RST_PRESC 10'h000
`define T8_BOTTOM 8'h00
`define T8_MAX 8'hFF

// ----------------------------------------------------------------
// Prescaler terminal counts
// ----------------------------------------------------------------
`define T8_DIV8_END 10'h007
`define T8_DIV64_END 10'h03F
`define T8_DIV256_END 10'h0FF
`define T8_DIV1024_END 10'h3FF

`endif

// >>> include/t8_pkg.sv
package t8_pkg;

    // Waveform generation modes; unlisted codes run as normal mode
    typedef enum logic [2:0] {
        T8_NORMAL = 3'b000,
        T8_PC_MAX = 3'b001,
        T8_CTC = 3'b010,
        T8_FAST_MAX = 3'b011,
        T8_PC_CMP = 3'b101,
        T8_FAST_CMP = 3'b111
    } t8_mode_t;

    // Tick source selections
    typedef enum logic [2:0] {
        T8_SRC_OFF = 3'b000,
        T8_SRC_DIV1 = 3'b001,
        T8_SRC_DIV8 = 3'b010,
        T8_SRC_DIV64 = 3'b011,
        T8_SRC_DIV256 = 3'b100,
        T8_SRC_DIV1024 = 3'b101,
        T8_SRC_EXT_FALL = 3'b110,
        T8_SRC_EXT_RISE = 3'b111
    } t8_src_t;

    // Whole state of the timer
    typedef struct packed {
        logic [7:0] count_value_reg;
        logic [7:0] compare_value_a;
        logic [7:0] compare_value_b;
        logic [7:0] buf_a;
        logic [7:0] buf_b;
        logic [7:0] ctrl_a;
        logic [2:0] tick_source_select;
        logic wgm_hi;
        logic [2:0] timer_mask_reg;
        logic [2:0] timer_flag_reg;
        logic [2:0] irq;
        logic count_down;
        logic block;
        logic [9:0] presc;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic wave_out_a;
        logic wave_out_b;
        logic [7:0] rdata;
    } t8_state_t;

endpackage

// >>> design/t8_timer.sv
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "t8_defs.svh"

module t8_timer (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // External count pin
    input wire logic ext_count_pin_i,
    // Interrupt service
    input wire logic [2:0] irq_ack_i,
    output logic [2:0] irq_req_o,
    // Waveform pins
    output logic wave_out_a_o,
    output logic wave_out_b_o,
    output logic wave_en_a_o,
    output logic wave_en_b_o,
    // Tick observation
    output logic timer_tick_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Action on a match outside PWM: toggle, clear or set
    function automatic logic act_plain(input logic [1:0] com,
                                       input logic cur);
        logic res;
        res = cur;
        case (com)
            2'b01: res = ~cur;
            2'b10: res = 1'b0;
            2'b11: res = 1'b1;
            default: res = cur;
        endcase
        return res;
    endfunction

    // PWM action: com 2 drives lvl, com 3 drives its inverse
    function automatic logic act_pwm(input logic [1:0] com,
                                     input logic cur,
                                     input logic lvl,
                                     input logic tog_ok);
        logic res;
        res = cur;
        case (com)
            2'b01: res = tog_ok ? ~cur : cur;
            2'b10: res = lvl;
            2'b11: res = ~lvl;
            default: res = cur;
        endcase
        return res;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    t8_pkg::t8_state_t st;
    t8_pkg::t8_state_t next_st;
    t8_pkg::t8_mode_t mode;
    logic [7:0] top_val;
    logic pwm;
    logic fast;
    logic tick;
    logic match_a;
    logic match_b;
    logic wrap;
    logic at_top;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic tog_a;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        flag_set = 3'h0;
        flag_clr = 3'h0;
        wrap = 1'b0;
        at_top = 1'b0;
        tick = 1'b0;
        com_a = st.ctrl_a[`T8_CA_COM_A];
        com_b = st.ctrl_a[`T8_CA_COM_B];

        // Mode decode; reserved codes fall back to normal counting
        case ({st.wgm_hi, st.ctrl_a[`T8_CA_WGM_LO]})
            3'b001: mode = t8_pkg::T8_PC_MAX;
            3'b010: mode = t8_pkg::T8_CTC;
            3'b011: mode = t8_pkg::T8_FAST_MAX;
            3'b101: mode = t8_pkg::T8_PC_CMP;
            3'b111: mode = t8_pkg::T8_FAST_CMP;
            default: mode = t8_pkg::T8_NORMAL;
        endcase
        fast = (mode == t8_pkg::T8_FAST_MAX) ||
               (mode == t8_pkg::T8_FAST_CMP);
        pwm = fast || (mode == t8_pkg::T8_PC_MAX) ||
              (mode == t8_pkg::T8_PC_CMP);
        tog_a = (mode == t8_pkg::T8_FAST_CMP) ||
                (mode == t8_pkg::T8_PC_CMP);
        // Top is fixed maximum or compare A
        top_val = (mode == t8_pkg::T8_CTC || tog_a) ?
                  st.compare_value_a : `T8_MAX;

        // Pin sync: first stage feeds only the second
        next_st.ext_s1 = ext_count_pin_i;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_s3 = st.ext_s2;

        // Prescaler runs only while a source is selected
        if (st.tick_source_select == t8_pkg::T8_SRC_OFF) begin
            next_st.presc = `T8_RST_PRESC;
        end else begin
            next_st.presc = st.presc + 10'h001;
        end

        // Clock select: source and edge give the tick
        case (t8_pkg::t8_src_t'(st.tick_source_select))
            t8_pkg::T8_SRC_DIV1: tick = 1'b1;
            t8_pkg::T8_SRC_DIV8: tick = (st.presc[2:0] == 3'h7);
            t8_pkg::T8_SRC_DIV64: tick = (st.presc[5:0] == 6'h3F);
            t8_pkg::T8_SRC_DIV256: tick = (st.presc[7:0] == 8'hFF);
            t8_pkg::T8_SRC_DIV1024: tick = (st.presc == `T8_DIV1024_END);
            t8_pkg::T8_SRC_EXT_FALL: tick = st.ext_s3 & ~st.ext_s2;
            t8_pkg::T8_SRC_EXT_RISE: tick = ~st.ext_s3 & st.ext_s2;
            default: tick = 1'b0;
        endcase

        // Continuous compare, blocked one tick after a count write
        match_a = (st.count_value_reg == st.compare_value_a) &&
                  !st.block;
        match_b = (st.count_value_reg == st.compare_value_b) &&
                  !st.block;

        // Tick: flags from the match held since the last tick
        if (tick) begin
            next_st.block = 1'b0;
            flag_set[`T8_FLG_MA] = match_a;
            flag_set[`T8_FLG_MB] = match_b;
            if (pwm && !fast) begin
                // Phase correct: up to top, down to bottom
                if (!st.count_down) begin
                    if (st.count_value_reg == top_val) begin
                        at_top = 1'b1;
                        next_st.count_down = 1'b1;
                        next_st.count_value_reg =
                            st.count_value_reg - 8'h01;
                    end else begin
                        next_st.count_value_reg =
                            st.count_value_reg + 8'h01;
                    end
                end else if (st.count_value_reg == `T8_BOTTOM) begin
                    next_st.count_down = 1'b0;
                    flag_set[`T8_FLG_OVF] = 1'b1;
                    next_st.count_value_reg = st.count_value_reg + 8'h01;
                end else begin
                    next_st.count_value_reg = st.count_value_reg - 8'h01;
                end
            end else if (fast ||
                         mode == t8_pkg::T8_CTC) begin
                // Wrap to bottom at top: auto reload
                if (st.count_value_reg == top_val) begin
                    next_st.count_value_reg = `T8_BOTTOM;
                    wrap = 1'b1;
                end else begin
                    next_st.count_value_reg = st.count_value_reg + 8'h01;
                end
                flag_set[`T8_FLG_OVF] = fast ? wrap :
                    (st.count_value_reg == `T8_MAX);
            end else begin
                next_st.count_value_reg = st.count_value_reg + 8'h01;
                flag_set[`T8_FLG_OVF] =
                    (st.count_value_reg == `T8_MAX);
            end

            // Buffered compares load at top or wrap, never mid-period
            if (pwm && (at_top || wrap)) begin
                next_st.compare_value_a = st.buf_a;
                next_st.compare_value_b = st.buf_b;
            end

            // Waveform generator
            if (!pwm) begin
                if (match_a) begin
                    next_st.wave_out_a = act_plain(com_a, st.wave_out_a);
                end
                if (match_b) begin
                    next_st.wave_out_b = act_plain(com_b, st.wave_out_b);
                end
            end else if (fast) begin
                // Fast PWM: match drives one level, bottom the other
                if (match_a) begin
                    next_st.wave_out_a = act_pwm(com_a, st.wave_out_a,
                                                 1'b0, tog_a);
                end else if (wrap) begin
                    next_st.wave_out_a = act_pwm(com_a, st.wave_out_a,
                                                 1'b1, 1'b0);
                end
                if (match_b) begin
                    next_st.wave_out_b = act_pwm(com_b, st.wave_out_b,
                                                 1'b0, 1'b0);
                end else if (wrap) begin
                    next_st.wave_out_b = act_pwm(com_b, st.wave_out_b,
                                                 1'b1, 1'b0);
                end
            end else begin
                // Phase correct: level follows count direction
                if (match_a) begin
                    next_st.wave_out_a = act_pwm(com_a, st.wave_out_a,
                                                 st.count_down,
                                                 tog_a);
                end
                if (match_b) begin
                    next_st.wave_out_b = act_pwm(com_b, st.wave_out_b,
                                                 st.count_down,
                                                 1'b0);
                end
            end
        end

        // Software access; register writes land after the tick logic
        if (wr_i) begin
            if (addr_i == `T8_OFS_CTRL_A) begin
                next_st.ctrl_a = wdata_i & `T8_CA_WMASK;
            end else if (addr_i == `T8_OFS_CTRL_B) begin
                next_st.tick_source_select = wdata_i[`T8_CB_SEL];
                next_st.wgm_hi = wdata_i[`T8_CB_WGM_HI];
                // Force strobes act like a match outside PWM modes but set no flag
                if (!pwm && wdata_i[`T8_CB_FORCE_A]) begin
                    next_st.wave_out_a = act_plain(com_a, st.wave_out_a);
                end
                if (!pwm && wdata_i[`T8_CB_FORCE_B]) begin
                    next_st.wave_out_b = act_plain(com_b, st.wave_out_b);
                end
            end else if (addr_i == `T8_OFS_COUNT) begin
                next_st.count_value_reg = wdata_i;
                next_st.count_down = st.count_down;
                next_st.block = 1'b1;
            end else if (addr_i == `T8_OFS_CMP_A) begin
                next_st.buf_a = wdata_i;
                if (!pwm) begin
                    next_st.compare_value_a = wdata_i;
                end
            end else if (addr_i == `T8_OFS_CMP_B) begin
                next_st.buf_b = wdata_i;
                if (!pwm) begin
                    next_st.compare_value_b = wdata_i;
                end
            end else if (addr_i == `T8_OFS_MASK) begin
                next_st.timer_mask_reg = wdata_i[2:0];
            end else if (addr_i == `T8_OFS_FLAG) begin
                flag_clr = wdata_i[2:0];
            end
        end

        // Service or write-one clears; a same-cycle set still wins
        next_st.timer_flag_reg = (st.timer_flag_reg & ~flag_clr &
                                  ~irq_ack_i) | flag_set;
        next_st.irq = next_st.timer_flag_reg &
                      next_st.timer_mask_reg;

        // Read data stand only in the cycle after the strobe
        next_st.rdata = `T8_RST_BYTE;
        if (rd_i) begin
            if (addr_i == `T8_OFS_CTRL_A) begin
                next_st.rdata = st.ctrl_a;
            end else if (addr_i == `T8_OFS_CTRL_B) begin
                next_st.rdata = {4'h0, st.wgm_hi, st.tick_source_select};
            end else if (addr_i == `T8_OFS_COUNT) begin
                next_st.rdata = st.count_value_reg;
            end else if (addr_i == `T8_OFS_CMP_A) begin
                next_st.rdata = st.buf_a;
            end else if (addr_i == `T8_OFS_CMP_B) begin
                next_st.rdata = st.buf_b;
            end else if (addr_i == `T8_OFS_MASK) begin
                next_st.rdata = {5'h00, st.timer_mask_reg};
            end else if (addr_i == `T8_OFS_FLAG) begin
                next_st.rdata = {5'h00, st.timer_flag_reg};
            end else begin
                next_st.rdata = `T8_RST_BYTE;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st.count_value_reg <= `T8_RST_BYTE;
            st.compare_value_a <= `T8_RST_BYTE;
            st.compare_value_b <= `T8_RST_BYTE;
            st.buf_a <= `T8_RST_BYTE;
            st.buf_b <= `T8_RST_BYTE;
            st.ctrl_a <= `T8_RST_BYTE;
            st.tick_source_select <= `T8_RST_BITS3;
            st.wgm_hi <= 1'b0;
            st.timer_mask_reg <= `T8_RST_BITS3;
            st.timer_flag_reg <= `T8_RST_BITS3;
            st.irq <= `T8_RST_BITS3;
            st.count_down <= 1'b0;
            st.block <= 1'b0;
            st.presc <= `T8_RST_PRESC;
            st.ext_s1 <= 1'b0;
            st.ext_s2 <= 1'b0;
            st.ext_s3 <= 1'b0;
            st.wave_out_a <= 1'b0;
            st.wave_out_b <= 1'b0;
            st.rdata <= `T8_RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Pin override follows the compare output mode, as the port would
    assign rdata_o = st.rdata;
    assign irq_req_o = st.irq;
    assign wave_out_a_o = st.wave_out_a;
    assign wave_out_b_o = st.wave_out_b;
    assign wave_en_a_o = |st.ctrl_a[`T8_CA_COM_A];
    assign wave_en_b_o = |st.ctrl_a[`T8_CA_COM_B];
    assign timer_tick_o = tick;

endmodule

// >>> bench/t8_timer_monitor.sv
`timescale 1ns/1ps

// ----------------------------------------
// Port checker for the timer
// ----------------------------------------
module t8_timer_monitor (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Pins
    input wire logic ext_count_pin_i,
    input wire logic [2:0] irq_ack_i,
    input wire logic [2:0] irq_req_o,
    input wire logic wave_out_a_o,
    input wire logic wave_out_b_o,
    input wire logic wave_en_a_o,
    input wire logic wave_en_b_o,
    input wire logic timer_tick_o
);
    logic [2:0] sel;
    logic [2:0] msk;
    logic [2:0] msk_q;
    logic [10:0] gap;
    logic [10:0] want;
    logic seen;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // Shadow select and mask; gap restarts on a select write so that
    // the first, partial prescaler period is never judged
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sel <= 3'h0;
            msk <= 3'h0;
            msk_q <= 3'h0;
            gap <= 11'h000;
            seen <= 1'b0;
        end else begin
            msk_q <= msk;
            if (wr_i && addr_i == 4'h5) begin
                msk <= wdata_i[2:0];
            end
            if (wr_i && addr_i == 4'h1) begin
                sel <= wdata_i[2:0];
                seen <= 1'b0;
                gap <= 11'h000;
            end else if (timer_tick_o) begin
                seen <= 1'b1;
                gap <= 11'h000;
            end else begin
                gap <= gap + 11'h001;
            end
        end
    end

    // Idle cycles expected between two prescaled ticks
    always_comb begin
        case (sel)
            3'h1: want = 11'h000;
            3'h2: want = 11'h007;
            3'h3: want = 11'h03F;
            3'h4: want = 11'h0FF;
            default: want = 11'h3FF;
        endcase
    end

    a_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside read slot");
    a_reset_all_zero: assert property ($fell(reset_i) |->
        irq_req_o == 3'h0 && rdata_o == 8'h00 && !wave_out_a_o
        && !wave_out_b_o && !wave_en_a_o && !wave_en_b_o)
        else $error("outputs not zero after reset");
    a_off_no_tick: assert property (sel == 3'h0 |-> !timer_tick_o)
        else $error("tick while no source selected");
    a_presc_gap: assert property ((timer_tick_o && seen && sel != 3'h0
        && sel < 3'h6) |-> gap == want)
        else $error("prescaled tick spacing wrong");
    a_mask_gate: assert property ((irq_req_o & ~msk & ~msk_q) == 3'h0)
        else $error("request raised while masked");
    a_ack_clears: assert property ((|irq_ack_i && !timer_tick_o) |=>
        (irq_req_o & $past(irq_ack_i)) == 3'h0)
        else $error("service ack did not clear request");
    a_wave_enable: assert property ((wr_i && addr_i == 4'h0) |=>
        wave_en_a_o == ($past(wdata_i[7:6]) != 2'b00)
        && wave_en_b_o == ($past(wdata_i[5:4]) != 2'b00))
        else $error("wave enable does not follow mode bits");
    a_mask_readback: assert property ((wr_i && addr_i == 4'h5) ##1
        (rd_i && addr_i == 4'h5) |=> rdata_o == {5'h00,
        $past(wdata_i[2:0], 2)})
        else $error("mask read back wrong");
    a_count_wins: assert property ((wr_i && addr_i == 4'h2) ##1
        (rd_i && addr_i == 4'h2) |=> rdata_o == $past(wdata_i, 2))
        else $error("count write lost to count or clear");
    a_unmapped_zero: assert property ((rd_i && addr_i > 4'h6) |=>
        rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind t8_timer t8_timer_monitor t8_timer_monitor_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_count_pin_i(ext_count_pin_i), .irq_ack_i(irq_ack_i),
    .irq_req_o(irq_req_o), .wave_out_a_o(wave_out_a_o),
    .wave_out_b_o(wave_out_b_o), .wave_en_a_o(wave_en_a_o),
    .wave_en_b_o(wave_en_b_o), .timer_tick_o(timer_tick_o)
);

// >>> bench/t8_timer_tb_top.sv
`timescale 1ns/1ps

// ----------------------------------------
// Timer testbench
// ----------------------------------------
module t8_timer_tb_top;
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } t8_row_t;

    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ext_count_pin_i = 1'b0;
    logic [2:0] irq_ack_i = 3'h0;
    logic [7:0] rdata_o;
    logic [2:0] irq_req_o;
    logic wave_out_a_o;
    logic wave_out_b_o;
    logic wave_en_a_o;
    logic wave_en_b_o;
    logic timer_tick_o;
    logic rd_q = 1'b0;
    logic lvl;
    logic [7:0] last_rd;
    int bad_count = 0;
    int n_checks = 0;
    int ticks = 0;
    int ka;
    int kb;
    int tg;
    t8_row_t rows [10];
    int divs [5] = '{1, 8, 64, 256, 1024};

    t8_timer t8_timer_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ext_count_pin_i(ext_count_pin_i), .irq_ack_i(irq_ack_i),
        .irq_req_o(irq_req_o), .wave_out_a_o(wave_out_a_o),
        .wave_out_b_o(wave_out_b_o), .wave_en_a_o(wave_en_a_o),
        .wave_en_b_o(wave_en_b_o), .timer_tick_o(timer_tick_o)
    );

    // 25 MHz clock
    always #20 clk_sys_i = ~clk_sys_i;

    // Read data stands one cycle only, so catch it mid-cycle
    always @(posedge clk_sys_i) rd_q <= rd_i;
    always @(negedge clk_sys_i) begin
        if (rd_q) last_rd = rdata_o;
        if (timer_tick_o === 1'b1) ticks++;
    end

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One strobe cycle; a following bus call may reuse the slot
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
    endtask

    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        irq_ack_i <= 3'h0;
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        idle(1);
    endtask

    task automatic rchk(input string nm, input logic [3:0] a,
                        input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        idle(1);
        chk(nm, last_rd, e);
    endtask

    // Requests are registered, so look at them mid-cycle
    task automatic req_chk(input string nm, input logic [7:0] e);
        @(negedge clk_sys_i);
        chk(nm, {5'h00, irq_req_o}, e);
        @(posedge clk_sys_i);
    endtask

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run is about 6000 cycles; a hang is ended by the watchdog at 20000
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        stop_test();
    end

    initial begin
        rows = '{'{4'h5, 8'hFF, 8'h07}, '{4'h3, 8'hA5, 8'hA5},
                 '{4'h4, 8'h5A, 8'h5A}, '{4'h2, 8'h3C, 8'h3C},
                 '{4'h0, 8'hFF, 8'hF3}, '{4'h1, 8'hC8, 8'h08},
                 '{4'h6, 8'hFF, 8'h00}, '{4'h0, 8'h00, 8'h00},
                 '{4'h1, 8'h00, 8'h00}, '{4'hF, 8'hFF, 8'h00}};
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rchk("reset_value", i[3:0], 8'h00);
        end
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, rows[i].a, rows[i].d);
            rchk("reg_readback", rows[i].a, rows[i].e);
        end
        done("registers");
        // Match flags come one tick after the counter meets compare
        wreg(4'h5, 8'h07);
        wreg(4'h3, 8'h02);
        wreg(4'h4, 8'h04);
        wreg(4'h2, 8'h00);
        wreg(4'h6, 8'h07);
        wreg(4'h1, 8'h01);
        ka = 0;
        kb = 0;
        for (int k = 1; k < 12; k++) begin
            @(negedge clk_sys_i);
            if (ka == 0 && irq_req_o[1] === 1'b1) ka = k;
            if (kb == 0 && irq_req_o[2] === 1'b1) kb = k;
            @(posedge clk_sys_i);
        end
        chk("match_a_cycle", ka[7:0], 8'h03);
        chk("match_b_cycle", kb[7:0], 8'h05);
        done("match");
        // Clear on match with top 3 toggles every fourth tick
        wreg(4'h1, 8'h00);
        wreg(4'h6, 8'h07);
        wreg(4'h2, 8'h00);
        wreg(4'h3, 8'h03);
        wreg(4'h0, 8'h42);
        chk("wave_en_a", {7'h00, wave_en_a_o}, 8'h01);
        wreg(4'h1, 8'h01);
        idle(8);
        tg = 0;
        @(negedge clk_sys_i);
        lvl = wave_out_a_o;
        repeat (32) begin
            @(negedge clk_sys_i);
            if (wave_out_a_o !== lvl) tg++;
            lvl = wave_out_a_o;
        end
        @(posedge clk_sys_i);
        chk("ctc_toggles", tg[7:0], 8'h08);
        repeat (5) begin
            bus(1'b0, 4'h2, 8'h00);
            idle(2);
            chk("ctc_top", {7'h00, last_rd > 8'h03}, 8'h00);
        end
        req_chk("no_overflow", 8'h02);
        done("clear_on_match");
        // Masking, service ack and write-one clear
        wreg(4'h1, 8'h00);
        wreg(4'h5, 8'h01);
        req_chk("masked_req", 8'h00);
        rchk("flags_visible", 4'h6, 8'h02);
        wreg(4'h5, 8'h07);
        req_chk("unmasked_req", 8'h02);
        irq_ack_i <= 3'b010;
        @(posedge clk_sys_i);
        idle(1);
        req_chk("ack_clears", 8'h00);
        wreg(4'h0, 8'h00);
        wreg(4'h3, 8'h80);
        wreg(4'h4, 8'h80);
        wreg(4'h2, 8'hFE);
        wreg(4'h1, 8'h01);
        idle(6);
        wreg(4'h1, 8'h00);
        req_chk("overflow_req", 8'h01);
        wreg(4'h6, 8'h01);
        rchk("w1c_flag", 4'h6, 8'h00);
        done("flags");
        // Stopped counter stays put; a count write beats a tick
        wreg(4'h2, 8'h80);
        idle(10);
        rchk("stopped_count", 4'h2, 8'h80);
        wreg(4'h1, 8'h01);
        bus(1'b1, 4'h2, 8'h55);
        bus(1'b0, 4'h2, 8'h00);
        idle(1);
        chk("count_write_wins", last_rd, 8'h55);
        for (int i = 0; i < 5; i++) begin
            wreg(4'h1, 8'(i + 1));
            ticks = 0;
            repeat (4 * divs[i]) @(posedge clk_sys_i);
            chk("prescale_ticks", 8'(ticks), 8'h04);
        end
        for (int s = 6; s < 8; s++) begin
            wreg(4'h1, 8'(s));
            ticks = 0;
            repeat (3) begin
                ext_count_pin_i <= 1'b1;
                idle(5);
                ext_count_pin_i <= 1'b0;
                idle(5);
            end
            chk("ext_edge_ticks", 8'(ticks), 8'h03);
        end
        done("tick_sources");
        // Force strobe in normal mode sets B as a match would
        wreg(4'h0, 8'h30);
        wreg(4'h1, 8'h40);
        chk("force_b", {7'h00, wave_out_b_o}, 8'h01);
        done("force");
        // Reset in mid-run
        wreg(4'h0, 8'hF0);
        reset_i <= 1'b1;
        idle(2);
        reset_i <= 1'b0;
        rchk("rerun_mask", 4'h5, 8'h00);
        chk("rerun_en", {6'h00, wave_en_a_o, wave_en_b_o}, 8'h00);
        done("second_reset");
        stop_test();
    end
endmodule
